// [verilog/current_dac_pkg.sv]
/*
 * constants for the current-output converter front end: register addresses,
 * field positions, reset values and update-source encodings.
 * assumes an 8-bit special-function register bus driven by the processor core.
 */
package current_dac_pkg;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [7:0] ADDR_DATA_LOW = 8'h96;
	localparam logic [7:0] ADDR_DATA_HIGH = 8'h97;
	localparam logic [7:0] ADDR_CONTROL = 8'hb9;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RESET_CONTROL = 8'h72;
	localparam logic [7:0] RESET_DATA_LOW = 8'h00;
	localparam logic [7:0] RESET_DATA_HIGH = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int ENABLE_BIT = 7;
	localparam int SOURCE_MSB = 6;
	localparam int SOURCE_LSB = 4;
	localparam int RANGE_MSB = 1;
	localparam int RANGE_LSB = 0;
	localparam int LOW_DATA_MSB = 7;
	localparam int LOW_DATA_LSB = 6;
	// implemented bits of each register; the rest read zero
	localparam logic [7:0] CONTROL_MASK = 8'hf3;
	localparam logic [7:0] DATA_LOW_MASK = 8'hc0;

	// ****************************************
	// update sources
	// ****************************************
	typedef enum logic [2:0] {
		SRC_TIMER0 = 3'b000,
		SRC_TIMER1 = 3'b001,
		SRC_TIMER2 = 3'b010,
		SRC_TIMER3 = 3'b011,
		SRC_STROBE_RISE = 3'b100,
		SRC_STROBE_FALL = 3'b101,
		SRC_STROBE_ANY = 3'b110,
		SRC_HIGH_WRITE = 3'b111
	} update_source_t;

endpackage : current_dac_pkg

// [verilog/strobe_edge_detect.sv]
/*
 * synchroniser and edge detector for the external convert strobe pin.
 * assumes the pin is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module strobe_edge_detect (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic strobe_pin,
	output logic rise_pulse,
	output logic fall_pulse
);

	logic sync_first;
	logic sync_second;
	logic sync_prev;

	// ****************************************
	// two-stage synchroniser, then history for edges
	// ****************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync_first <= 1'b0;
			sync_second <= 1'b0;
			sync_prev <= 1'b0;
		end else begin
			sync_first <= strobe_pin;
			sync_second <= sync_first;
			sync_prev <= sync_second;
		end
	end

	// single-cycle pulse per edge; the first stage feeds nothing but the second
	assign rise_pulse = sync_second & ~sync_prev;
	assign fall_pulse = ~sync_second & sync_prev;

endmodule : strobe_edge_detect

// [verilog/current_dac_update_scheduler.sv]
/*
 * register file and update scheduler of the 10-bit current-output converter.
 * assumes a processor core doing single-cycle special-function register
 * reads and writes on clk_sys, and timer overflow pulses one cycle wide.
 */
`timescale 1ns/1ps
module current_dac_update_scheduler #(
	// the source field has two bits for timers, so exactly four can be served
	parameter int TIMER_COUNT = 4
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_write,
	input wire logic sfr_read,
	input wire logic [7:0] sfr_write_data,
	output logic [7:0] sfr_read_data,
	output logic sfr_read_hit,
	input wire logic [TIMER_COUNT-1:0] timer_overflow,
	input wire logic external_convert_strobe,
	output logic [9:0] latched_word,
	output logic update_pulse,
	output logic converter_enable_bit,
	output logic [1:0] full_scale_select,
	output logic range_half_ma,
	output logic range_one_ma,
	output logic range_two_ma,
	output logic pin_analog_connect,
	output logic pin_digital_driver_off,
	output logic pin_pullup_off
);

	logic [7:0] dac_control;
	logic [7:0] dac_data_low_byte;
	logic [7:0] dac_data_high_byte;
	logic write_low;
	logic write_high;
	logic write_control;
	logic strobe_rise;
	logic strobe_fall;
	logic trigger;
	current_dac_pkg::update_source_t source;
	logic [7:0] next_high;
	logic [1:0] next_low;

	// ****************************************
	// elaboration checks
	// ****************************************
	// another count would leave source codes with no timer, or timers with no code
	if (TIMER_COUNT != 4) begin : g_timer_count_check
		$error("timer count must be four");
	end

	// ****************************************
	// helpers
	// ****************************************
	// one address match shared by every write decode
	function automatic logic is_addr(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction : is_addr

	// left-justified word: the whole high byte, then the top two bits of the low byte
	function automatic logic [9:0] join_word(input logic [7:0] high, input logic [1:0] low);
		return {high, low};
	endfunction : join_word

	// ****************************************
	// register decode
	// ****************************************
	assign write_low = sfr_write && is_addr(sfr_addr, current_dac_pkg::ADDR_DATA_LOW);
	assign write_high = sfr_write && is_addr(sfr_addr, current_dac_pkg::ADDR_DATA_HIGH);
	assign write_control = sfr_write && is_addr(sfr_addr, current_dac_pkg::ADDR_CONTROL);
	assign source = current_dac_pkg::update_source_t'(
		dac_control[current_dac_pkg::SOURCE_MSB:current_dac_pkg::SOURCE_LSB]);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dac_control <= current_dac_pkg::RESET_CONTROL;
		end else if (write_control) begin
			dac_control <= sfr_write_data & current_dac_pkg::CONTROL_MASK;
		end
	end

	// both bytes take every write at once; only the converter latch waits for the event
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dac_data_low_byte <= current_dac_pkg::RESET_DATA_LOW;
		end else if (write_low) begin
			dac_data_low_byte <= sfr_write_data & current_dac_pkg::DATA_LOW_MASK;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dac_data_high_byte <= current_dac_pkg::RESET_DATA_HIGH;
		end else if (write_high) begin
			dac_data_high_byte <= sfr_write_data;
		end
	end

	// unmapped addresses read zero and drop the hit flag
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sfr_read_data <= 8'h00;
			sfr_read_hit <= 1'b0;
		end else begin
			sfr_read_hit <= 1'b0;
			sfr_read_data <= 8'h00;
			if (sfr_read) begin
				unique case (sfr_addr)
					current_dac_pkg::ADDR_DATA_LOW: begin
						sfr_read_data <= dac_data_low_byte;
						sfr_read_hit <= 1'b1;
					end
					current_dac_pkg::ADDR_DATA_HIGH: begin
						sfr_read_data <= dac_data_high_byte;
						sfr_read_hit <= 1'b1;
					end
					current_dac_pkg::ADDR_CONTROL: begin
						sfr_read_data <= dac_control;
						sfr_read_hit <= 1'b1;
					end
					default: begin
						sfr_read_data <= 8'h00;
					end
				endcase
			end
		end
	end

	// ****************************************
	// update event selection
	// ****************************************
	strobe_edge_detect strobe_edges (
		.clk_sys(clk_sys),
		.rst(rst),
		.strobe_pin(external_convert_strobe),
		.rise_pulse(strobe_rise),
		.fall_pulse(strobe_fall)
	);

	// changing the source is not an update event by itself; an edge already in the
	// synchroniser when the source changes is judged against the new source
	always_comb begin
		trigger = 1'b0;
		unique case (source)
			current_dac_pkg::SRC_TIMER0: trigger = timer_overflow[0];
			current_dac_pkg::SRC_TIMER1: trigger = timer_overflow[1];
			current_dac_pkg::SRC_TIMER2: trigger = timer_overflow[2];
			current_dac_pkg::SRC_TIMER3: trigger = timer_overflow[3];
			current_dac_pkg::SRC_STROBE_RISE: trigger = strobe_rise;
			current_dac_pkg::SRC_STROBE_FALL: trigger = strobe_fall;
			current_dac_pkg::SRC_STROBE_ANY: trigger = strobe_rise | strobe_fall;
			current_dac_pkg::SRC_HIGH_WRITE: trigger = write_high;
		endcase
	end

	// ****************************************
	// converter input latches
	// ****************************************
	// a byte written in the triggering cycle is taken straight from the bus,
	// so the latch never lags the register by one update
	assign next_high = write_high ? sfr_write_data : dac_data_high_byte;
	assign next_low = write_low ? sfr_write_data[current_dac_pkg::LOW_DATA_MSB:current_dac_pkg::LOW_DATA_LSB]
		: dac_data_low_byte[current_dac_pkg::LOW_DATA_MSB:current_dac_pkg::LOW_DATA_LSB];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			update_pulse <= 1'b0;
		end else begin
			update_pulse <= trigger;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			latched_word <= 10'h000;
		end else if (trigger) begin
			latched_word <= join_word(next_high, next_low);
		end
	end

	// ****************************************
	// analog stage controls
	// ****************************************
	// range strobes are registered from the value being written, so they move on the
	// same edge as the control register and carry no decode glitch to the analog side
	function automatic logic [2:0] range_decode(input logic [1:0] select);
		return {select[1], (select == 2'h1), (select == 2'h0)};
	endfunction : range_decode

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{range_two_ma, range_one_ma, range_half_ma} <= range_decode(
				current_dac_pkg::RESET_CONTROL[current_dac_pkg::RANGE_MSB:current_dac_pkg::RANGE_LSB]);
		end else if (write_control) begin
			{range_two_ma, range_one_ma, range_half_ma} <= range_decode(
				sfr_write_data[current_dac_pkg::RANGE_MSB:current_dac_pkg::RANGE_LSB]);
		end
	end

	assign converter_enable_bit = dac_control[current_dac_pkg::ENABLE_BIT];
	assign full_scale_select = dac_control[current_dac_pkg::RANGE_MSB:current_dac_pkg::RANGE_LSB];
	assign pin_analog_connect = converter_enable_bit;
	assign pin_digital_driver_off = converter_enable_bit;
	assign pin_pullup_off = converter_enable_bit;

endmodule : current_dac_update_scheduler

// [verif/current_dac_props.sv]
/* checker for the converter front end: sees the top ports only; the bench binds it */
`timescale 1ns/1ps
module current_dac_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_write,
	input wire logic sfr_read,
	input wire logic [7:0] sfr_write_data,
	input wire logic [7:0] sfr_read_data,
	input wire logic [3:0] timer_overflow,
	input wire logic external_convert_strobe,
	input wire logic [9:0] latched_word,
	input wire logic update_pulse,
	input wire logic converter_enable_bit,
	input wire logic [1:0] full_scale_select,
	input wire logic range_two_ma,
	input wire logic pin_analog_connect
);
	logic [2:0] src;
	logic [7:0] wd;
	// shadow of the source field: the register itself is not a port
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			src <= 3'h7;
		end else if (sfr_write && sfr_addr == 8'hb9) begin
			src <= sfr_write_data[6:4];
		end
	end
	always_ff @(posedge clk_sys) begin
		wd <= sfr_write_data;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_high_write_latch: assert property (src == 3'h7 && sfr_write && sfr_addr == 8'h97 |=>
		update_pulse && latched_word[9:2] == wd) else $error("high write missed latch");
	a_other_write_hold: assert property (src == 3'h7 && !(sfr_write && sfr_addr == 8'h97) |=>
		!update_pulse) else $error("latch without high write");
	a_timer_update: assert property (!src[2] && timer_overflow[src[1:0]] |=> update_pulse)
		else $error("timer update missed");
	a_timer_hold: assert property (!src[2] && !timer_overflow[src[1:0]] |=> !update_pulse)
		else $error("timer mode latched early");
	a_strobe_rise: assert property (src == 3'h4 && $rose(external_convert_strobe) |->
		##3 update_pulse ##1 !update_pulse) else $error("strobe update wrong");
	a_low_gap_zero: assert property (sfr_read && sfr_addr == 8'h96 |=> sfr_read_data[5:0] == 6'h00)
		else $error("low byte gap not zero");
	a_control_gap_zero: assert property (sfr_read && sfr_addr == 8'hb9 |=> sfr_read_data[3:2] == 2'h0)
		else $error("control gap not zero");
	a_control_fields: assert property (sfr_write && sfr_addr == 8'hb9 |=>
		full_scale_select == wd[1:0] && converter_enable_bit == wd[7] && pin_analog_connect == wd[7]
		&& range_two_ma == wd[1]) else $error("control fields wrong");
endmodule : current_dac_props

// [verif/current_dac_core_model.sv]
/* processor core model: register cycles, timer overflows and strobe pin; changes at the falling edge */
`timescale 1ns/1ps
module current_dac_core_model (
	input wire logic clk_sys,
	input wire logic [7:0] sfr_read_data,
	output logic [7:0] sfr_addr,
	output logic sfr_write,
	output logic sfr_read,
	output logic [7:0] sfr_write_data,
	output logic [3:0] timer_overflow,
	output logic external_convert_strobe
);
	initial begin
		{sfr_addr, sfr_write, sfr_read, sfr_write_data, timer_overflow, external_convert_strobe} = '0;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_write_data = d;
		sfr_write = 1'b1;
		@(negedge clk_sys);
		sfr_write = 1'b0;
		// released data must not look like a held value
		sfr_write_data = ~d;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_read = 1'b1;
		@(negedge clk_sys);
		sfr_read = 1'b0;
		d = sfr_read_data;
	endtask : rd
	task pulse(input logic [3:0] t);
		@(negedge clk_sys);
		timer_overflow = t;
		@(negedge clk_sys);
		timer_overflow = 4'h0;
	endtask : pulse
	// pin level held three cycles so the synchroniser surely sees it
	task edge_to(input logic v);
		@(negedge clk_sys);
		external_convert_strobe = v;
		repeat (3) @(negedge clk_sys);
	endtask : edge_to
endmodule : current_dac_core_model

// [verif/test_current_dac_update_scheduler.sv]
/* self-checking bench: each update source against an integer model; the core model drives the bus */
`timescale 1ns/1ps
module test_current_dac_update_scheduler;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sfr_addr, sfr_write_data, sfr_read_data, d;
	logic sfr_write, sfr_read, sfr_read_hit, update_pulse, converter_enable_bit, external_convert_strobe;
	logic range_half_ma, range_one_ma, range_two_ma, pin_analog_connect, pin_digital_driver_off, pin_pullup_off;
	logic [3:0] timer_overflow;
	logic [9:0] latched_word;
	logic [1:0] full_scale_select;
	int n_fail = 0, comparisons = 0, seed = 32'hc2ab, hi, lo, ctl, exp_word = 0;
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	current_dac_core_model i_core (.*);
	current_dac_update_scheduler i_dut (.*);
	task chk(input string what, input logic [9:0] e, input logic [9:0] s);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test
	// a full run takes under two hundred cycles; this is far beyond it
	initial begin
		#100000;
		n_fail++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys) rst = 1'b0;
		i_core.rd(8'hb9, d);
		chk("control", 10'h072, 10'(d));
		chk("hit", 10'h001, 10'(sfr_read_hit));
		i_core.rd(8'h97, d);
		chk("high", 10'h000, 10'(d));
		for (int s = 0; s < 8; s++) begin
			ctl = $random(seed);
			i_core.wr(8'hb9, {ctl[7], 3'(s), ctl[3:0]});
			ctl = {ctl[7], 3'(s), 2'b00, ctl[1:0]};
			i_core.rd(8'hb9, d);
			chk("control", 10'(ctl), 10'(d));
			chk("hit", 10'h001, 10'(sfr_read_hit));
			chk("pins", {{3{ctl[7]}}, 4'h0, ctl[1], (ctl[1:0] == 2'b01), (ctl[1:0] == 2'b00)},
				{pin_analog_connect, pin_digital_driver_off, pin_pullup_off, 4'h0,
				range_two_ma, range_one_ma, range_half_ma});
			lo = $random(seed);
			hi = $random(seed);
			i_core.wr(8'h96, 8'(lo));
			i_core.wr(8'h97, 8'(hi));
			if (s == 7) exp_word = {hi[7:0], lo[7:6]};
			chk("latch", 10'(exp_word), latched_word);
			i_core.rd(8'h96, d);
			chk("low", 10'(lo & 8'hc0), 10'(d));
			i_core.wr(8'h96, 8'h00);
			if (s < 4) begin
				i_core.pulse(4'(~(1 << s)));
				chk("latch", 10'(exp_word), latched_word);
				i_core.pulse(4'(1 << s));
			end else if (s < 7) begin
				i_core.edge_to(s != 5);
			end else begin
				i_core.pulse(4'hf);
				i_core.edge_to(1'b0);
				chk("latch", 10'(exp_word), latched_word);
				i_core.wr(8'h97, 8'(hi));
			end
			exp_word = {hi[7:0], 2'b00};
			chk("latch", 10'(exp_word), latched_word);
			$display("source %0d done", s);
		end
		end_of_test();
	end
endmodule : test_current_dac_update_scheduler
bind current_dac_update_scheduler current_dac_props i_props (.*);
